// >>> shared/pes_pkg.sv
package pes_pkg;
    // Commit classification
    localparam int COMMIT_W = 3;
    localparam logic [2:0] COMMIT_MAX = 3'h4;
    localparam logic [2:0] GPR_WRITE_PORTS = 3'h2;
    // L2 geometry
    localparam int L2_BANKS = 4;
    localparam int BANK_W = 2;
    localparam logic [3:0] BLOCK_REFS = 4'h8;
    localparam int REF_W = 4;
    // Outstanding-miss tracking
    localparam int OUT_W = 5;
    localparam int MSHR_ENTRIES = 16;
    // Software prefetch outcome codes
    typedef enum logic [1:0] {
        PES_SWPF_L2   = 2'b00,
        PES_SWPF_DROP = 2'b01,
        PES_SWPF_HIT  = 2'b10
    } pes_swpf_t;
endpackage

// >>> shared/pes_miss_if.sv
`timescale 1ns/1ps
// Carries one cache's miss start/finish strobes to a tracker
interface pes_miss_if;
    logic start;
    logic done;
    logic busy;
    logic [pes_pkg::OUT_W-1:0] outstanding;
    modport src (output start, output done, input busy, input outstanding);
    modport trk (input start, input done, output busy, output outstanding);
endinterface

// >>> design/pes_miss_tracker.sv
`timescale 1ns/1ps
// Outstanding-miss tracker: count of misses in flight and busy level
module pes_miss_tracker (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Miss strobes and results
    pes_miss_if.trk m
);
    logic [pes_pkg::OUT_W-1:0] cnt_r;
    logic [pes_pkg::OUT_W-1:0] cnt_nxt;
    wire logic inc = m.start & ~m.done;
    wire logic dec = m.done & ~m.start & (cnt_r != '0);

    // Saturate at zero so a stray done cannot wrap the count
    assign cnt_nxt = inc ? cnt_r + pes_pkg::OUT_W'(1) :
                     dec ? cnt_r - pes_pkg::OUT_W'(1) : cnt_r;
    assign m.outstanding = cnt_r;
    assign m.busy = (cnt_r != '0);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// >>> design/pes_event_sources.sv
`timescale 1ns/1ps
// Function
// R1: Separate flags for cycles committing exactly one, two or three instructions.
// R2: Flag short commit cycles caused by the two-update integer write limit.
// R3: Flag every cycle halted by wait-halt or low-power-halt.
// R4: Flag only low-power-halt cycles separately.
// R5: Flag cycles whose sole commit is an unpacked prefix; also zero-commit.
// R6: One event per instruction and per data micro-TLB miss.
// R7: One event per L1 instruction and per L1 data miss.
// R8: Per L1, latency flag while any miss outstanding, overlap counted once.
// R9: Event per main TLB lookup caused by a micro-TLB miss, per side.
// R10: Each software prefetch classified as forwarded, dropped or L1 hit.
// R11: Per L1, thrashing event on second L2 read within one store port.
// R12: Core-caused L2 events to own core only; external ones to all.
// R13: L2 request demand if L1 resources held, else or hardware prefetch.
// R14: L2 references split demand/prefetch, block op adds eight, external not demand.
// R15: Per-bank L2 miss events split; totals equal sum of banks.
// R16: Demand hitting outstanding prefetch miss: no demand miss, latency from arrival.
// R17: Per bank, latency sums every outstanding miss, demand and prefetch.
// R18: Writeback events split by demand or prefetch causing miss.
// R19: Separate lost-prefetch events for port full and pipe abort.
// R20: CPU and I/O reads/writes separate; I/O write full-line only, partial apart.
// R21: External invalidate and cache-read counts chip-wide, same for all cores.
// R22: Copy-and-invalidate and copyback selectors kept but never generated.
// R23: Flag zero-commit cycles, including prefix-only commit cycles.
// R24: Each event is an increment valid for exactly one clock.
// R25: Latency events: one per cycle, or outstanding count where summed.
module pes_event_sources #(
    parameter int NUM_CORES = 2,
    parameter int CORE_ID = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Commit stage
    input wire logic [2:0] commit_count,
    input wire logic commit_sole_prefix,
    input wire logic commit_gpr_limited,
    input wire logic halt_wait,
    input wire logic halt_low_power,
    // MMU
    input wire logic inst_micro_tlb_miss_in,
    input wire logic data_micro_tlb_miss_in,
    input wire logic inst_main_tlb_read,
    input wire logic data_main_tlb_read,
    // L1 caches
    input wire logic inst_l1_miss_start,
    input wire logic inst_l1_miss_done,
    input wire logic data_l1_miss_start,
    input wire logic data_l1_miss_done,
    input wire logic inst_l1_l2_read,
    input wire logic inst_l1_port_release,
    input wire logic data_l1_l2_read,
    input wire logic data_l1_port_release,
    // Software prefetch at load/store unit
    input wire logic swpf_valid,
    input wire logic [1:0] swpf_outcome,
    // Level-2 cache unit request
    input wire logic l2_req_valid,
    input wire logic [NUM_CORES-1:0] l2_req_core,
    input wire logic l2_req_external,
    input wire logic l2_req_l1_res,
    input wire logic l2_req_hw_pf,
    input wire logic l2_req_block,
    input wire logic l2_req_miss,
    input wire logic l2_req_hit_pf_miss,
    input wire logic [1:0] l2_req_bank,
    input wire logic l2_req_wb,
    input wire logic [pes_pkg::L2_BANKS-1:0] l2_dm_done,
    input wire logic [pes_pkg::L2_BANKS-1:0] l2_pf_done,
    input wire logic [pes_pkg::L2_BANKS-1:0] l2_pf_upgrade,
    input wire logic pf_lost_full,
    input wire logic pf_lost_abort,
    // Memory bus
    input wire logic bus_cpu_read,
    input wire logic bus_cpu_write,
    input wire logic bus_io_read,
    input wire logic bus_io_write_full,
    input wire logic bus_io_write_part,
    input wire logic snoop_invalidate,
    input wire logic snoop_read,
    // Core events
    output logic commit_zero_cycles,
    output logic commit_one_cycles,
    output logic commit_two_cycles,
    output logic commit_three_cycles,
    output logic write_port_commit_stall,
    output logic halt_any_cycles,
    output logic halt_low_power_cycles,
    output logic sole_prefix_cycles,
    // MMU and L1 events
    output logic inst_micro_tlb_miss,
    output logic data_micro_tlb_miss,
    output logic inst_main_tlb_lookup,
    output logic data_main_tlb_lookup,
    output logic inst_l1_miss,
    output logic data_l1_miss,
    output logic inst_l1_miss_busy_cycles,
    output logic data_l1_miss_busy_cycles,
    output logic swpf_to_l2,
    output logic swpf_dropped,
    output logic swpf_l1_hit,
    output logic inst_l1_refill_evicted,
    output logic data_l1_refill_evicted,
    // L2 events
    output logic [pes_pkg::REF_W-1:0] l2_demand_refs,
    output logic [pes_pkg::REF_W-1:0] l2_prefetch_refs,
    output logic l2_demand_misses,
    output logic l2_prefetch_misses,
    output logic [pes_pkg::L2_BANKS-1:0] l2_demand_misses_per_bank,
    output logic [pes_pkg::L2_BANKS-1:0] l2_prefetch_misses_per_bank,
    output logic [pes_pkg::L2_BANKS*pes_pkg::OUT_W-1:0] l2_demand_latency_per_bank,
    output logic [pes_pkg::L2_BANKS*pes_pkg::OUT_W-1:0] l2_prefetch_latency_per_bank,
    output logic l2_demand_writebacks,
    output logic l2_prefetch_writebacks,
    output logic prefetch_drop_port_full,
    output logic prefetch_drop_pipe_abort,
    // Bus events
    output logic cpu_mem_reads,
    output logic cpu_mem_writes,
    output logic io_mem_reads,
    output logic full_line_store_request,
    output logic partial_store_request,
    output logic ext_invalidate_requests,
    output logic ext_read_requests,
    output logic ext_copy_inval_requests,
    output logic ext_copyback_requests
);
    localparam int BK = pes_pkg::L2_BANKS;
    localparam int OW = pes_pkg::OUT_W;

    // ==========================================================
    // Commit classification
    wire logic cnt_zero = (commit_count == 3'h0) | commit_sole_prefix; // [R23] [R5]
    wire logic cnt_one = (commit_count == 3'h1) & ~commit_sole_prefix; // [R1]
    wire logic cnt_two = (commit_count == 3'h2); // [R1]
    wire logic cnt_three = (commit_count == 3'h3); // [R1]
    // Only a short commit can be blamed on the write ports
    wire logic gpr_stall = commit_gpr_limited & (commit_count < pes_pkg::COMMIT_MAX)
        & (commit_count >= pes_pkg::GPR_WRITE_PORTS); // [R2]
    wire logic halted = halt_wait | halt_low_power; // [R3]

    // ==========================================================
    // L1 miss trackers
    pes_miss_if imiss ();
    pes_miss_if dmiss ();
    assign imiss.start = inst_l1_miss_start;
    assign imiss.done = inst_l1_miss_done;
    assign dmiss.start = data_l1_miss_start;
    assign dmiss.done = data_l1_miss_done;
    pes_miss_tracker u_itrk (.clk(clk), .srst(srst), .m(imiss));
    pes_miss_tracker u_dtrk (.clk(clk), .srst(srst), .m(dmiss));

    // Thrashing: a second L2 read while the store port is held
    logic i_port_read_r;
    logic d_port_read_r;
    wire logic i_thrash = inst_l1_l2_read & i_port_read_r; // [R11]
    wire logic d_thrash = data_l1_l2_read & d_port_read_r; // [R11]

    // ==========================================================
    // Software prefetch
    wire logic swpf_l2 = swpf_valid & (swpf_outcome == pes_pkg::PES_SWPF_L2); // [R10]
    wire logic swpf_drop = swpf_valid & (swpf_outcome == pes_pkg::PES_SWPF_DROP); // [R10]
    // Reserved outcome code counted as hit so every prefetch lands once
    wire logic swpf_hit_w = swpf_valid & ~swpf_l2 & ~swpf_drop; // [R10]

    // ==========================================================
    // L2 attribution and classification
    wire logic l2_mine = l2_req_valid & (l2_req_external | l2_req_core[CORE_ID]); // [R12]
    wire logic l2_is_pf = l2_req_hw_pf | ~l2_req_l1_res; // [R13]
    wire logic l2_dm = l2_mine & ~l2_is_pf & ~l2_req_external; // [R14]
    wire logic l2_pf = l2_mine & l2_is_pf; // [R13]
    wire logic [pes_pkg::REF_W-1:0] l2_refs =
        l2_req_block ? pes_pkg::BLOCK_REFS : pes_pkg::REF_W'(1); // [R14]
    // Demand joining an in-flight prefetch miss is no new demand miss
    wire logic dm_miss = l2_dm & l2_req_miss & ~l2_req_hit_pf_miss; // [R16]
    wire logic pf_miss = l2_pf & l2_req_miss; // [R15]
    wire logic [BK-1:0] bank_sel = BK'(1) << l2_req_bank;
    wire logic [BK-1:0] dm_bank = {BK{dm_miss}} & bank_sel; // [R15]
    wire logic [BK-1:0] pf_bank = {BK{pf_miss}} & bank_sel; // [R15]
    // Demand that hits an in-flight prefetch starts demand latency now
    wire logic [BK-1:0] dm_join = {BK{l2_dm & l2_req_hit_pf_miss}} & bank_sel; // [R16]

    // Per-bank latency trackers
    logic [BK*OW-1:0] dm_out;
    logic [BK*OW-1:0] pf_out;
    genvar gb;
    generate
        for (gb = 0; gb < BK; gb++) begin : g_bank
            pes_miss_if dmq ();
            pes_miss_if pfq ();
            assign dmq.start = dm_bank[gb] | dm_join[gb]; // [R17]
            assign dmq.done = l2_dm_done[gb];
            assign pfq.start = pf_bank[gb]; // [R17]
            assign pfq.done = l2_pf_done[gb] | l2_pf_upgrade[gb];
            pes_miss_tracker u_dm (.clk(clk), .srst(srst), .m(dmq));
            pes_miss_tracker u_pf (.clk(clk), .srst(srst), .m(pfq));
            assign dm_out[gb*OW +: OW] = dmq.outstanding;
            assign pf_out[gb*OW +: OW] = pfq.outstanding;
        end
    endgenerate

    // ==========================================================
    // Registered outputs: every event valid for exactly one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            commit_zero_cycles <= 1'b0;
            commit_one_cycles <= 1'b0;
            commit_two_cycles <= 1'b0;
            commit_three_cycles <= 1'b0;
            write_port_commit_stall <= 1'b0;
            halt_any_cycles <= 1'b0;
            halt_low_power_cycles <= 1'b0;
            sole_prefix_cycles <= 1'b0;
            inst_micro_tlb_miss <= 1'b0;
            data_micro_tlb_miss <= 1'b0;
            inst_main_tlb_lookup <= 1'b0;
            data_main_tlb_lookup <= 1'b0;
            inst_l1_miss <= 1'b0;
            data_l1_miss <= 1'b0;
            inst_l1_miss_busy_cycles <= 1'b0;
            data_l1_miss_busy_cycles <= 1'b0;
            swpf_to_l2 <= 1'b0;
            swpf_dropped <= 1'b0;
            swpf_l1_hit <= 1'b0;
            inst_l1_refill_evicted <= 1'b0;
            data_l1_refill_evicted <= 1'b0;
            i_port_read_r <= 1'b0;
            d_port_read_r <= 1'b0;
        end else begin
            commit_zero_cycles <= cnt_zero; // [R23] [R24]
            commit_one_cycles <= cnt_one; // [R1]
            commit_two_cycles <= cnt_two; // [R1]
            commit_three_cycles <= cnt_three; // [R1]
            write_port_commit_stall <= gpr_stall; // [R2]
            halt_any_cycles <= halted; // [R3]
            halt_low_power_cycles <= halt_low_power; // [R4]
            sole_prefix_cycles <= commit_sole_prefix; // [R5]
            inst_micro_tlb_miss <= inst_micro_tlb_miss_in; // [R6]
            data_micro_tlb_miss <= data_micro_tlb_miss_in; // [R6]
            inst_main_tlb_lookup <= inst_main_tlb_read & inst_micro_tlb_miss_in; // [R9]
            data_main_tlb_lookup <= data_main_tlb_read & data_micro_tlb_miss_in; // [R9]
            inst_l1_miss <= inst_l1_miss_start; // [R7]
            data_l1_miss <= data_l1_miss_start; // [R7]
            inst_l1_miss_busy_cycles <= imiss.busy; // [R8] [R25]
            data_l1_miss_busy_cycles <= dmiss.busy; // [R8] [R25]
            swpf_to_l2 <= swpf_l2; // [R10]
            swpf_dropped <= swpf_drop; // [R10]
            swpf_l1_hit <= swpf_hit_w; // [R10]
            inst_l1_refill_evicted <= i_thrash; // [R11]
            data_l1_refill_evicted <= d_thrash; // [R11]
            // Release ends the port window and wins; the next read opens a new one
            i_port_read_r <= inst_l1_port_release ? 1'b0 : (i_port_read_r | inst_l1_l2_read);
            d_port_read_r <= data_l1_port_release ? 1'b0 : (d_port_read_r | data_l1_l2_read);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            l2_demand_refs <= '0;
            l2_prefetch_refs <= '0;
            l2_demand_misses <= 1'b0;
            l2_prefetch_misses <= 1'b0;
            l2_demand_misses_per_bank <= '0;
            l2_prefetch_misses_per_bank <= '0;
            l2_demand_latency_per_bank <= '0;
            l2_prefetch_latency_per_bank <= '0;
            l2_demand_writebacks <= 1'b0;
            l2_prefetch_writebacks <= 1'b0;
            prefetch_drop_port_full <= 1'b0;
            prefetch_drop_pipe_abort <= 1'b0;
        end else begin
            l2_demand_refs <= l2_dm ? l2_refs : '0; // [R14]
            l2_prefetch_refs <= l2_pf ? l2_refs : '0; // [R14]
            l2_demand_misses <= |dm_bank; // [R15]
            l2_prefetch_misses <= |pf_bank; // [R15]
            l2_demand_misses_per_bank <= dm_bank; // [R15]
            l2_prefetch_misses_per_bank <= pf_bank; // [R15]
            l2_demand_latency_per_bank <= dm_out; // [R17] [R25]
            l2_prefetch_latency_per_bank <= pf_out; // [R17] [R25]
            l2_demand_writebacks <= dm_miss & l2_req_wb; // [R18]
            l2_prefetch_writebacks <= pf_miss & l2_req_wb; // [R18]
            prefetch_drop_port_full <= pf_lost_full; // [R19]
            prefetch_drop_pipe_abort <= pf_lost_abort; // [R19]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cpu_mem_reads <= 1'b0;
            cpu_mem_writes <= 1'b0;
            io_mem_reads <= 1'b0;
            full_line_store_request <= 1'b0;
            partial_store_request <= 1'b0;
            ext_invalidate_requests <= 1'b0;
            ext_read_requests <= 1'b0;
            ext_copy_inval_requests <= 1'b0;
            ext_copyback_requests <= 1'b0;
        end else begin
            cpu_mem_reads <= bus_cpu_read; // [R20]
            cpu_mem_writes <= bus_cpu_write; // [R20]
            io_mem_reads <= bus_io_read; // [R20]
            full_line_store_request <= bus_io_write_full; // [R20]
            partial_store_request <= bus_io_write_part; // [R20]
            // Chip-wide snoops reach every core unfiltered
            ext_invalidate_requests <= snoop_invalidate; // [R21]
            ext_read_requests <= snoop_read; // [R21]
            // Selectors kept for compatibility, never fire
            ext_copy_inval_requests <= 1'b0; // [R22]
            ext_copyback_requests <= 1'b0; // [R22]
        end
    end

    // ==========================================================
    // Assertions
    property p_commit_onehot;
        @(posedge clk) disable iff (srst)
        !$past(srst) |-> $onehot0({commit_zero_cycles, commit_one_cycles,
            commit_two_cycles, commit_three_cycles});
    endproperty
    a_commit_onehot: assert property (p_commit_onehot) else $error("commit flags clash"); // [R1]

    property p_prefix_zero;
        @(posedge clk) disable iff (srst)
        sole_prefix_cycles |-> commit_zero_cycles;
    endproperty
    a_prefix_zero: assert property (p_prefix_zero) else $error("prefix cycle not zero"); // [R5]

    property p_low_power;
        @(posedge clk) disable iff (srst)
        halt_low_power_cycles |-> halt_any_cycles;
    endproperty
    a_low_power: assert property (p_low_power) else $error("low-power halt not halted"); // [R4]

    property p_swpf_one;
        @(posedge clk) disable iff (srst)
        swpf_valid |=> $onehot({swpf_to_l2, swpf_dropped, swpf_l1_hit});
    endproperty
    a_swpf_one: assert property (p_swpf_one) else $error("prefetch outcome not unique"); // [R10]

    property p_dm_sum;
        @(posedge clk) disable iff (srst)
        l2_demand_misses == (|l2_demand_misses_per_bank);
    endproperty
    a_dm_sum: assert property (p_dm_sum) else $error("demand miss total mismatch"); // [R15]

    property p_block_refs;
        @(posedge clk) disable iff (srst)
        (l2_dm && l2_req_block) |=> (l2_demand_refs == pes_pkg::BLOCK_REFS);
    endproperty
    a_block_refs: assert property (p_block_refs) else $error("block ref not eight"); // [R14]

    property p_join_no_miss;
        @(posedge clk) disable iff (srst)
        (l2_req_valid && l2_req_hit_pf_miss) |=> !l2_demand_misses;
    endproperty
    a_join_no_miss: assert property (p_join_no_miss) else $error("joined demand missed"); // [R16]

    property p_l1_busy;
        @(posedge clk) disable iff (srst)
        (inst_l1_miss_start && !inst_l1_miss_done) |=> ##1 inst_l1_miss_busy_cycles;
    endproperty
    a_l1_busy: assert property (p_l1_busy) else $error("L1 miss latency not flagged"); // [R8]

    property p_no_compat;
        @(posedge clk) disable iff (srst)
        !ext_copy_inval_requests && !ext_copyback_requests;
    endproperty
    a_no_compat: assert property (p_no_compat) else $error("compat event fired"); // [R22]
endmodule

// >>> testbench/pes_counter_model.sv
`timescale 1ns/1ps
// =========================================
// Counter unit model
module pes_counter_model #(
    parameter int N = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Five-bit increments in, running totals out
    input wire logic [N*5-1:0] inc,
    output int tot [N]
);
    // Adds each slice once per edge, so a pulse seen twice shows as a double count
    always @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            tot[i] <= srst ? 0 : tot[i] + int'(inc[i*5 +: 5]);
        end
    end
endmodule

// >>> testbench/pes_event_sources_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

module pes_event_sources_test;
    // =========================================
    // Signals
    logic clk = 1'b0;
    logic srst, swpf_valid, pad_unused, l2_req_valid;
    logic [2:0] commit_count;
    logic commit_sole_prefix, commit_gpr_limited, halt_wait, halt_low_power;
    logic inst_micro_tlb_miss_in, data_micro_tlb_miss_in, inst_main_tlb_read, data_main_tlb_read;
    logic inst_l1_miss_start, inst_l1_miss_done, data_l1_miss_start, data_l1_miss_done;
    logic inst_l1_l2_read, inst_l1_port_release, data_l1_l2_read, data_l1_port_release;
    logic [1:0] swpf_outcome, l2_req_core, l2_req_bank;
    logic l2_req_external, l2_req_l1_res, l2_req_hw_pf, l2_req_block, l2_req_miss;
    logic l2_req_hit_pf_miss, l2_req_wb, pf_lost_full, pf_lost_abort, snoop_read;
    logic [3:0] l2_dm_done, l2_pf_done, l2_pf_upgrade, l1p;
    logic bus_cpu_read, bus_cpu_write, bus_io_read, bus_io_write_full, bus_io_write_part;
    logic snoop_invalidate, commit_zero_cycles, commit_one_cycles, commit_two_cycles;
    logic commit_three_cycles, write_port_commit_stall, halt_any_cycles, halt_low_power_cycles;
    logic sole_prefix_cycles, inst_micro_tlb_miss, data_micro_tlb_miss, inst_main_tlb_lookup;
    logic data_main_tlb_lookup, inst_l1_miss, data_l1_miss, inst_l1_miss_busy_cycles;
    logic data_l1_miss_busy_cycles, swpf_to_l2, swpf_dropped, swpf_l1_hit;
    logic inst_l1_refill_evicted, data_l1_refill_evicted, l2_demand_misses, l2_prefetch_misses;
    logic [3:0] l2_demand_refs, l2_prefetch_refs;
    logic [3:0] l2_demand_misses_per_bank, l2_prefetch_misses_per_bank;
    logic [19:0] l2_demand_latency_per_bank, l2_prefetch_latency_per_bank;
    logic l2_demand_writebacks, l2_prefetch_writebacks, prefetch_drop_port_full;
    logic prefetch_drop_pipe_abort, cpu_mem_reads, cpu_mem_writes, io_mem_reads;
    logic full_line_store_request, partial_store_request, ext_invalidate_requests;
    logic ext_read_requests, ext_copy_inval_requests, ext_copyback_requests;
    logic [23:0] inv;
    logic [27:0] outv;
    logic [10:0] l2r;
    logic [44:0] inc;
    int tot [9];
    int errors = 0;
    int n_compared = 0;
    assign {commit_count, commit_sole_prefix, commit_gpr_limited, halt_wait, halt_low_power,
            swpf_valid, swpf_outcome, inst_micro_tlb_miss_in, data_micro_tlb_miss_in,
            inst_main_tlb_read, data_main_tlb_read, pf_lost_full, pf_lost_abort, bus_cpu_read,
            bus_cpu_write, bus_io_read, bus_io_write_full, bus_io_write_part, snoop_invalidate,
            snoop_read, pad_unused} = inv;
    // Both L1 sides share one pattern so their trackers see identical traffic
    assign {inst_l1_miss_start, inst_l1_miss_done, inst_l1_l2_read, inst_l1_port_release} = l1p;
    assign {data_l1_miss_start, data_l1_miss_done, data_l1_l2_read, data_l1_port_release} = l1p;
    assign {l2_req_core, l2_req_external, l2_req_l1_res, l2_req_hw_pf, l2_req_block, l2_req_miss,
            l2_req_hit_pf_miss, l2_req_bank, l2_req_wb} = l2r;
    assign outv = {commit_zero_cycles, commit_one_cycles, commit_two_cycles, commit_three_cycles,
            write_port_commit_stall, halt_any_cycles, halt_low_power_cycles, sole_prefix_cycles,
            inst_micro_tlb_miss, data_micro_tlb_miss, inst_main_tlb_lookup, data_main_tlb_lookup,
            swpf_to_l2, swpf_dropped, swpf_l1_hit, prefetch_drop_port_full,
            prefetch_drop_pipe_abort, cpu_mem_reads, cpu_mem_writes, io_mem_reads,
            full_line_store_request, partial_store_request, ext_invalidate_requests,
            ext_read_requests, ext_copy_inval_requests, ext_copyback_requests, 2'h0};
    assign inc = {l2_prefetch_latency_per_bank[9:5], l2_demand_latency_per_bank[14:10],
            l2_demand_latency_per_bank[9:5], 1'h0, l2_prefetch_refs, 1'h0, l2_demand_refs,
            4'h0, data_l1_refill_evicted, 4'h0, inst_l1_refill_evicted,
            4'h0, data_l1_miss_busy_cycles, 4'h0, inst_l1_miss_busy_cycles};

    pes_event_sources #(.NUM_CORES(2), .CORE_ID(0)) pes_event_sources_inst (.*);
    pes_counter_model #(.N(9)) pes_counter_model_inst (.clk(clk), .srst(srst), .inc(inc),
            .tot(tot));

    // =========================================
    // Stimulus tables
    logic [51:0] rows [14] = '{{24'h000000, 28'h8000000}, {24'h200000, 28'h4000000},
            {24'h400000, 28'h2000000}, {24'h680000, 28'h1800000}, {24'h800000, 28'h0000000},
            {24'h100000, 28'h8100000}, {24'h040000, 28'h8400000}, {24'h020000, 28'h8600000},
            {24'h813800, 28'h00E8000}, {24'h815C00, 28'h0054000}, {24'h818000, 28'h0002000},
            {24'h8003FE, 28'h0001FF0}, {24'h800008, 28'h0000040}, {24'h81C000, 28'h0002000}};
    logic [3:0] l1s [12] = '{4'h8, 4'h0, 4'hA, 4'h0, 4'h6, 4'h1, 4'h4, 4'h2, 4'h0, 4'h0,
            4'h0, 4'h0};
    logic [19:0] l2s [17] = '{20'hA8000, 20'hAA000, 20'hCA000, 20'h92000, 20'h98000,
            20'hAC000, 20'hA9500, 20'hA9400, 20'hA1300, 20'hA9A20, 20'h00000, 20'h00004,
            20'h00006, 20'h00000, 20'h00000, 20'h00000, 20'h00000};
    int exp_tot [9] = '{6, 6, 1, 1, 12, 10, 3, 10, 1};

    always #5 clk = ~clk;

    task automatic cyc();
        @(negedge clk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        inv = 24'h0;
        l1p = 4'h0;
        {l2_req_valid, l2r, l2_pf_upgrade, l2_dm_done} = 20'h0;
        l2_pf_done = 4'h0;
        repeat (5) cyc();
        srst = 1'b0;
        foreach (rows[i]) begin
            inv = rows[i][51:28];
            cyc();
            `CHK(outv[27:20], rows[i][27:20])
            `CHK(outv[19:0], rows[i][19:0])
        end
        done("table");
        inv = 24'h040000;
        srst = 1'b1;
        cyc();
        `CHK(outv, 28'h0)
        srst = 1'b0;
        cyc();
        `CHK(outv, 28'h8400000)
        inv = 24'h0;
        done("reset");
        foreach (l1s[i]) begin
            l1p = l1s[i];
            cyc();
            if (i == 0) `CHK({inst_l1_miss, data_l1_miss}, 2'h3)
            if (i == 4) `CHK({inst_l1_refill_evicted, data_l1_refill_evicted}, 2'h3)
        end
        done("l1");
        foreach (l2s[i]) begin
            {l2_req_valid, l2r, l2_pf_upgrade, l2_dm_done} = l2s[i];
            cyc();
            if (i == 1) `CHK(l2_demand_refs, 4'h8)
            if (i == 2) `CHK(l2_demand_refs, 4'h0)
            if (i == 6) begin
                `CHK(l2_demand_misses_per_bank, 4'h4)
                `CHK({l2_demand_misses, l2_demand_writebacks}, 2'h3)
            end
            if (i == 8) begin
                `CHK(l2_prefetch_misses_per_bank, 4'h2)
                `CHK({l2_prefetch_misses, l2_prefetch_writebacks}, 2'h3)
            end
            if (i == 9) `CHK({l2_demand_misses_per_bank, l2_demand_misses}, 5'h00)
        end
        // Totals via the counter model, so latency sums match what counters accumulate
        foreach (exp_tot[k]) `CHK(tot[k], exp_tot[k])
        // Prefetch miss in bank 3 retired by its own data return
        {l2_req_valid, l2r, l2_pf_upgrade, l2_dm_done} = 20'hA1600;
        cyc();
        `CHK(l2_prefetch_misses_per_bank, 4'h8)
        {l2_req_valid, l2r, l2_pf_upgrade, l2_dm_done} = 20'h0;
        l2_pf_done = 4'h8;
        cyc();
        `CHK(l2_prefetch_latency_per_bank[19:15], 5'h01)
        l2_pf_done = 4'h0;
        cyc();
        `CHK(l2_prefetch_latency_per_bank[19:15], 5'h00)
        done("l2");
        wrap_up();
    end

    initial begin
        #20000;
        errors++;
        wrap_up();
    end
endmodule
